// *** sles_lane.sv ***
/*
  sles_lane: one receive lane's error counters and status flags.
  Assumes error strobes are one-cycle pulses and sync inputs are levels,
  all synchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sles_lane
  import sles_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clk_en,
  input  wire logic             i_clear,
  input  wire logic [2:0]       i_err_event,
  input  wire logic [CNT_W-1:0] i_threshold,
  input  wire logic [4:0]       i_sync,
  output logic      [7:0]       o_flags,
  output logic      [3*CNT_W-1:0] o_counts,
  output logic                  o_err_rise,
  output logic                  o_lock_lost
);

  logic [CNT_W-1:0] cnt_r   [3];
  logic [CNT_W-1:0] cnt_nxt [3];
  logic [7:0]       flags_r;
  logic [7:0]       flags_nxt;
  logic             err_rise_r;
  logic             err_rise_nxt;
  logic             lock_lost_r;
  logic             lock_lost_nxt;

  // saturating counters, flags compared against the next count so they track it
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      cnt_nxt[k] = cnt_r[k];
      if (i_clear) begin
        cnt_nxt[k] = '0;
      end else if (i_err_event[k] && (cnt_r[k] != {CNT_W{1'b1}})) begin
        cnt_nxt[k] = cnt_r[k] + 1'b1;
      end
    end
    flags_nxt                  = FLAGS_RESET;
    flags_nxt[BIT_DISPARITY]   = (cnt_nxt[0] >= i_threshold);
    flags_nxt[BIT_INVALID_SYM] = (cnt_nxt[1] >= i_threshold);
    flags_nxt[BIT_UNEXP_CTRL]  = (cnt_nxt[2] >= i_threshold);
    // sync levels are sampled every enabled cycle, so a lost lock drops the flag
    flags_nxt[BIT_DESKEW]      = i_sync[4];
    flags_nxt[BIT_ALIGNMENT]   = i_sync[3];
    flags_nxt[BIT_CHECKSUM]    = i_sync[2];
    flags_nxt[BIT_FRAME_LOCK]  = i_sync[1];
    flags_nxt[BIT_SYMBOL_LOCK] = i_sync[0];
    err_rise_nxt  = |(flags_nxt[7:5] & ~flags_r[7:5]);
    lock_lost_nxt = flags_r[BIT_SYMBOL_LOCK] & ~flags_nxt[BIT_SYMBOL_LOCK];
  end

  // state registers, frozen while the clock enable is low
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < 3; k++) begin
        cnt_r[k] <= '0;
      end
      flags_r     <= FLAGS_RESET;
      err_rise_r  <= 1'b0;
      lock_lost_r <= 1'b0;
    end else if (i_clk_en) begin
      for (int k = 0; k < 3; k++) begin
        cnt_r[k] <= cnt_nxt[k];
      end
      flags_r     <= flags_nxt;
      err_rise_r  <= err_rise_nxt;
      lock_lost_r <= lock_lost_nxt;
    end
  end

  assign o_flags     = flags_r;
  assign o_counts    = {cnt_r[2], cnt_r[1], cnt_r[0]};
  assign o_err_rise  = err_rise_r;
  assign o_lock_lost = lock_lost_r;

endmodule
`default_nettype wire

// *** sles_pkg.sv ***
/*
  sles_pkg: constants shared by the lane status block and its lane leaf.
  Assumes a 32-bit APB slave at 100 MHz; every register is one aligned word
  and its byte address is four times its index.
*/
`default_nettype none
package sles_pkg;

  // lane range handled by this block
  localparam int unsigned LANE_FIRST = 4;
  localparam int unsigned LANE_COUNT = 3;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_LANE4_FLAGS = 12'h04B4;
  localparam logic [11:0] IDX_LANE5_FLAGS = 12'h04B5;
  localparam logic [11:0] IDX_LANE6_FLAGS = 12'h04B6;
  localparam logic [11:0] IDX_IRQ_STATUS  = 12'h04C0;
  localparam logic [11:0] IDX_IRQ_MASK    = 12'h04C1;
  localparam logic [11:0] IDX_CONTROL     = 12'h04C2;
  localparam logic [11:0] IDX_LANE4_COUNT = 12'h04C4;
  localparam logic [11:0] IDX_LANE5_COUNT = 12'h04C5;
  localparam logic [11:0] IDX_LANE6_COUNT = 12'h04C6;

  // flag bit positions inside each lane flags register
  localparam int unsigned BIT_DISPARITY   = 7;
  localparam int unsigned BIT_INVALID_SYM = 6;
  localparam int unsigned BIT_UNEXP_CTRL  = 5;
  localparam int unsigned BIT_DESKEW      = 4;
  localparam int unsigned BIT_ALIGNMENT   = 3;
  localparam int unsigned BIT_CHECKSUM    = 2;
  localparam int unsigned BIT_FRAME_LOCK  = 1;
  localparam int unsigned BIT_SYMBOL_LOCK = 0;

  // control register: bit 0 clears every error counter (self clearing)
  localparam int unsigned BIT_CTRL_CLEAR  = 0;

  // irq status layout: [2:0] error flag rose on lane 4..6, [5:3] symbol lock lost
  localparam int unsigned IRQ_ERR_LSB     = 0;
  localparam int unsigned IRQ_LOCK_LSB    = 3;
  localparam int unsigned IRQ_WIDTH       = 6;

  // reset values
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [7:0]  COUNT_RESET     = 8'h00;
  localparam logic [7:0]  COUNT_MAX       = 8'hFF;
  localparam logic [5:0]  IRQ_RESET       = 6'h00;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

endpackage
`default_nettype wire

// *** sles_top.sv ***
/*
  sles_top: per-lane sync and error status for receive lanes 4 to 6, with an
  APB register slave and a maskable level interrupt.
  Assumes all inputs synchronous to I_SYS_CLK, APB master per AMBA APB,
  error threshold and skip option driven from configuration logic elsewhere.
*/
// The APB register port was left to the implementer.
// Contract
// - bit 7 set when lane disparity error count reaches the threshold.
// - bit 6 set when lane not-in-table symbol count reaches the threshold.
// - bit 5 set when lane unexpected control count reaches the threshold.
// - bit 4 shows inter-lane deskew achieved (1) or failed (0).
// - bit 3 shows initial lane alignment achieved (1) or lost (0).
// - bit 2 shows lane configuration checksum correct (1) or incorrect (0).
// - bit 1 shows frame sync achieved (1) or lost (0).
// - bit 0 shows code group sync achieved (1) or lost (0).
// - flags are read-only, reset to zero, one register per lane, consecutive.
`timescale 1ns/1ps
`default_nettype none
module sles_top
  import sles_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             I_SYS_CLK,
  input  wire logic             I_RESET,
  input  wire logic             I_CLK_EN,
  // apb slave
  input  wire logic             I_PSEL,
  input  wire logic             I_PENABLE,
  input  wire logic             I_PWRITE,
  input  wire logic [15:0]      I_PADDR,
  input  wire logic [31:0]      I_PWDATA,
  output logic      [31:0]      O_PRDATA,
  output logic                  O_PREADY,
  output logic                  O_PSLVERR,
  // lane side: error strobes {unexp, invalid, disparity} per lane
  input  wire logic [8:0]       I_LANE_ERR_EVENT,
  // lane side: sync levels {deskew, align, checksum, frame, symbol} per lane
  input  wire logic [14:0]      I_LANE_SYNC,
  input  wire logic [CNT_W-1:0] I_ERROR_THRESHOLD,
  input  wire logic             I_SKIP_ALIGNMENT_SEQUENCE,
  output logic      [23:0]      O_LANE_FLAGS,
  output logic                  O_IRQ
);

  logic [7:0]         flags     [LANE_COUNT];
  logic [3*CNT_W-1:0] counts    [LANE_COUNT];
  logic [2:0]         err_rise;
  logic [2:0]         lock_lost;

  logic               clear_r;
  logic               clear_nxt;
  logic [5:0]         irq_status_r;
  logic [5:0]         irq_status_nxt;
  logic [5:0]         irq_mask_r;
  logic [5:0]         irq_mask_nxt;
  logic               irq_r;
  logic               irq_nxt;
  logic [31:0]        prdata_r;
  logic [31:0]        prdata_nxt;
  logic               pready_r;
  logic               pready_nxt;
  logic               pslverr_r;
  logic               pslverr_nxt;
  logic [23:0]        lane_flags_r;
  logic [23:0]        lane_flags_nxt;

  logic               setup;
  logic               wr_take;
  logic [11:0]        idx;
  logic               aligned;
  logic               hit_ro;
  logic               hit_rw;

  // one lane leaf per lane; counters cleared together from the control register
  for (genvar g = 0; g < LANE_COUNT; g++) begin : g_lane
    sles_lane #(
      .CNT_W (CNT_W)
    ) u_lane (
      .i_clk       (I_SYS_CLK),
      .i_reset     (I_RESET),
      .i_clk_en    (I_CLK_EN),
      .i_clear     (clear_r),
      .i_err_event (I_LANE_ERR_EVENT[3*g +: 3]),
      .i_threshold (I_ERROR_THRESHOLD),
      .i_sync      (I_LANE_SYNC[5*g +: 5]),
      .o_flags     (flags[g]),
      .o_counts    (counts[g]),
      .o_err_rise  (err_rise[g]),
      .o_lock_lost (lock_lost[g])
    );
  end

  // address decode; low two bits must be zero for a mapped word
  assign idx     = I_PADDR[13:2];
  assign aligned = (I_PADDR[1:0] == 2'b00) && (I_PADDR[15:14] == 2'b00);
  assign setup   = I_PSEL && !I_PENABLE;
  assign wr_take = I_PSEL && I_PENABLE && pready_r && I_PWRITE && !pslverr_r;

  // classify the addressed word: read-only flags and counts, or writable
  always_comb begin
    hit_ro = 1'b0;
    hit_rw = 1'b0;
    if (aligned) begin
      unique case (idx)
        IDX_LANE4_FLAGS, IDX_LANE5_FLAGS, IDX_LANE6_FLAGS,
        IDX_LANE4_COUNT, IDX_LANE5_COUNT, IDX_LANE6_COUNT: hit_ro = 1'b1;
        IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_CONTROL:         hit_rw = 1'b1;
        default: begin
          hit_ro = 1'b0;
          hit_rw = 1'b0;
        end
      endcase
    end
  end

  // bus answer: zero wait state, data and error latched in the setup cycle
  always_comb begin
    pready_nxt  = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    if (setup) begin
      // unmapped or a write into a read-only word is refused with an error
      pslverr_nxt = !(hit_rw || (hit_ro && !I_PWRITE));
      prdata_nxt  = RDATA_RESET;
      if (!I_PWRITE && aligned) begin
        unique case (idx)
          IDX_LANE4_FLAGS: prdata_nxt[7:0] = flags[0];
          IDX_LANE5_FLAGS: prdata_nxt[7:0] = flags[1];
          IDX_LANE6_FLAGS: prdata_nxt[7:0] = flags[2];
          IDX_LANE4_COUNT: prdata_nxt[3*CNT_W-1:0] = counts[0];
          IDX_LANE5_COUNT: prdata_nxt[3*CNT_W-1:0] = counts[1];
          IDX_LANE6_COUNT: prdata_nxt[3*CNT_W-1:0] = counts[2];
          IDX_IRQ_STATUS:  prdata_nxt[IRQ_WIDTH-1:0] = irq_status_r;
          IDX_IRQ_MASK:    prdata_nxt[IRQ_WIDTH-1:0] = irq_mask_r;
          IDX_CONTROL:     prdata_nxt = RDATA_RESET; // clear bit reads zero
          default:         prdata_nxt = RDATA_RESET;
        endcase
      end
    end
  end

  // software writes: mask, counter clear pulse, write-one-to-clear status
  always_comb begin
    irq_mask_nxt   = irq_mask_r;
    clear_nxt      = 1'b0;
    irq_status_nxt = irq_status_r;
    if (wr_take && (idx == IDX_IRQ_MASK)) begin
      irq_mask_nxt = I_PWDATA[IRQ_WIDTH-1:0];
    end
    if (wr_take && (idx == IDX_CONTROL)) begin
      clear_nxt = I_PWDATA[BIT_CTRL_CLEAR];
    end
    if (wr_take && (idx == IDX_IRQ_STATUS)) begin
      irq_status_nxt = irq_status_r & ~I_PWDATA[IRQ_WIDTH-1:0];
    end
    // new events applied after the clear so a same-cycle event is kept
    irq_status_nxt[IRQ_ERR_LSB +: 3]  = irq_status_nxt[IRQ_ERR_LSB +: 3] | err_rise;
    irq_status_nxt[IRQ_LOCK_LSB +: 3] = irq_status_nxt[IRQ_LOCK_LSB +: 3] | lock_lost;
    irq_nxt = |(irq_status_nxt & irq_mask_nxt);
  end

  // flags mirrored to pins untouched; the skip option does not gate them,
  // software must itself discount the alignment-related bits then
  always_comb begin
    lane_flags_nxt = {flags[2], flags[1], flags[0]};
  end

  // registers; clock enable low freezes the bus answer as well
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      clear_r      <= 1'b0;
      irq_status_r <= IRQ_RESET;
      irq_mask_r   <= IRQ_RESET;
      irq_r        <= 1'b0;
      prdata_r     <= RDATA_RESET;
      pready_r     <= 1'b0;
      pslverr_r    <= 1'b0;
      lane_flags_r <= '0;
    end else if (I_CLK_EN) begin
      clear_r      <= clear_nxt;
      irq_status_r <= irq_status_nxt;
      irq_mask_r   <= irq_mask_nxt;
      irq_r        <= irq_nxt;
      prdata_r     <= prdata_nxt;
      pready_r     <= pready_nxt;
      pslverr_r    <= pslverr_nxt;
      lane_flags_r <= lane_flags_nxt;
    end
  end

  assign O_PRDATA     = prdata_r;
  assign O_PREADY     = pready_r;
  assign O_PSLVERR    = pslverr_r;
  assign O_IRQ        = irq_r;
  assign O_LANE_FLAGS = lane_flags_r;

endmodule
`default_nettype wire

// *** sles_top_asserts.sv ***
/* sles_top_asserts: port timing checks for the lane status block, bound into sles_top.
   Assumes I_CLK_EN is only low while the lane sync inputs stand still. */
`timescale 1ns/1ps
`default_nettype none
module sles_top_asserts #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic             I_SYS_CLK,
  input wire logic             I_RESET,
  input wire logic [8:0]       I_LANE_ERR_EVENT,
  input wire logic [14:0]      I_LANE_SYNC,
  input wire logic [CNT_W-1:0] I_ERROR_THRESHOLD,
  input wire logic [23:0]      O_LANE_FLAGS,
  input wire logic             O_IRQ
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);
  logic [2:0]  up_r;
  logic [14:0] fl;
  // edges since reset; keeps history from before reset out of $past
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  // sync bits of the three lanes, packed in the input's order
  assign fl = {O_LANE_FLAGS[20:16], O_LANE_FLAGS[12:8], O_LANE_FLAGS[4:0]};
  sequence s_steady; up_r == 3'h7; endsequence
  property p_deskew; s_steady |-> ((fl ^ $past(I_LANE_SYNC, 2)) & 15'h4210) == 15'h0000; endproperty
  a_deskew: assert property (p_deskew) else $error("deskew flag off its input");
  property p_align; s_steady |-> ((fl ^ $past(I_LANE_SYNC, 2)) & 15'h2108) == 15'h0000; endproperty
  a_align: assert property (p_align) else $error("alignment flag off its input");
  property p_cksum; s_steady |-> ((fl ^ $past(I_LANE_SYNC, 2)) & 15'h1084) == 15'h0000; endproperty
  a_cksum: assert property (p_cksum) else $error("checksum flag off its input");
  property p_frame; s_steady |-> ((fl ^ $past(I_LANE_SYNC, 2)) & 15'h0842) == 15'h0000; endproperty
  a_frame: assert property (p_frame) else $error("frame lock flag off its input");
  property p_symbol; s_steady |-> ((fl ^ $past(I_LANE_SYNC, 2)) & 15'h0421) == 15'h0000; endproperty
  a_symbol: assert property (p_symbol) else $error("symbol lock flag off its input");
  // an error flag may only rise two edges after a pulse or a threshold change
  property p_disp_rise; s_steady ##0 $rose(O_LANE_FLAGS[7]) |->
    $past(I_LANE_ERR_EVENT[0], 2) || ($past(I_ERROR_THRESHOLD, 2) != $past(I_ERROR_THRESHOLD, 3)); endproperty
  a_disp_rise: assert property (p_disp_rise) else $error("disparity flag rose without cause");
  property p_inv_rise; s_steady ##0 $rose(O_LANE_FLAGS[14]) |->
    $past(I_LANE_ERR_EVENT[4], 2) || ($past(I_ERROR_THRESHOLD, 2) != $past(I_ERROR_THRESHOLD, 3)); endproperty
  a_inv_rise: assert property (p_inv_rise) else $error("invalid symbol flag rose without cause");
  property p_ctrl_rise; s_steady ##0 $rose(O_LANE_FLAGS[21]) |->
    $past(I_LANE_ERR_EVENT[8], 2) || ($past(I_ERROR_THRESHOLD, 2) != $past(I_ERROR_THRESHOLD, 3)); endproperty
  a_ctrl_rise: assert property (p_ctrl_rise) else $error("control char flag rose without cause");
  property p_reset; disable iff (1'b0) I_RESET |-> O_LANE_FLAGS == 24'h00_0000 && !O_IRQ; endproperty
  a_reset: assert property (p_reset) else $error("outputs not zero in reset");
endmodule
bind sles_top sles_top_asserts #(.CNT_W(CNT_W)) chk_u (.I_SYS_CLK, .I_RESET, .I_LANE_ERR_EVENT,
  .I_LANE_SYNC, .I_ERROR_THRESHOLD, .O_LANE_FLAGS, .O_IRQ);
`default_nettype wire

// *** sles_tx_model.sv ***
/* sles_tx_model: far-side transmitter stand-in; error bursts and lane sync levels.
   Assumes the bench holds i_kind, i_count and i_gap through a burst. */
`timescale 1ns/1ps
`default_nettype none
module sles_tx_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_req,
  input  wire logic [8:0]  i_kind,
  input  wire logic [7:0]  i_count,
  input  wire logic [1:0]  i_gap,
  input  wire logic [14:0] i_sync,
  output logic      [8:0]  o_err_event,
  output logic      [14:0] o_sync,
  output logic             o_busy
);
  logic [7:0] left_r;
  logic [1:0] wait_r;
  // one-cycle pulses, i_gap idle cycles apart, so slow links are covered too
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {left_r, wait_r, o_err_event, o_sync} <= '0;
    end else begin
      o_sync <= i_sync;
      o_err_event <= 9'h000;
      if (i_req) begin
        left_r <= i_count;
        wait_r <= 2'h0;
      end else if (left_r != 8'h00 && wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else if (left_r != 8'h00) begin
        o_err_event <= i_kind;
        left_r <= left_r - 8'h01;
        wait_r <= i_gap;
      end
    end
  end
  assign o_busy = i_req | (left_r != 8'h00);
endmodule
`default_nettype wire

// *** test_serial_lane_sync_error_status.sv ***
/* test_serial_lane_sync_error_status: APB bench for sles_top with a transmitter model.
   Assumes sles_tx_model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_serial_lane_sync_error_status
  import sles_pkg::*;
;
  logic        clk, rst, en, psel, pen, pwr, req, skip, pready, pslverr, irq, busy, e;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [8:0]  kind, ev;
  logic [14:0] sync, lsync;
  logic [7:0]  thr, cnt;
  logic [1:0]  gap;
  logic [23:0] flags;
  int          n_errors = 0, total_checks = 0;
  sles_tx_model tx_u (.i_clk(clk), .i_reset(rst), .i_req(req), .i_kind(kind), .i_count(cnt), .i_gap(gap),
    .i_sync(sync), .o_err_event(ev), .o_sync(lsync), .o_busy(busy));
  sles_top dut_u (.I_SYS_CLK(clk), .I_RESET(rst), .I_CLK_EN(en), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_LANE_ERR_EVENT(ev), .I_LANE_SYNC(lsync), .I_ERROR_THRESHOLD(thr),
    .I_SKIP_ALIGNMENT_SEQUENCE(skip), .O_LANE_FLAGS(flags), .O_IRQ(irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer, then an idle cycle so psel is never assigned twice in one step
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, 2'b00, idx, 2'b00, wd};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      results();
    end
    d = prdata;
    e = pslverr;
    {psel, pen} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [31:0] ex);
    xfer(1'b0, idx, 32'h0000_0000);
    chk("prdata", ex, d);
    chk("pslverr", 32'h0000_0000, {31'h0000_0000, e});
  endtask
  // burst from the transmitter model, then time for the flags to land
  task automatic send(input logic [8:0] k, input logic [7:0] c, input logic [1:0] g);
    int n;
    {req, kind, cnt, gap} <= {1'b1, k, c, g};
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy && n < 1200);
    if (busy) begin
      n_errors++;
      results();
    end
    repeat (4) @(posedge clk);
  endtask
  initial begin
    {psel, pen, pwr, paddr, pwdata, req, kind, cnt, gap, sync, skip} = '0;
    en = 1'b1;
    rst = 1'b1;
    thr = 8'h03;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, read-only words at consecutive places, unmapped word
    for (int i = 0; i < 3; i++) begin
      rdc(IDX_LANE4_FLAGS + 12'(i), 32'h0000_0000);
      xfer(1'b1, IDX_LANE4_FLAGS + 12'(i), 32'h0000_00FF);
      chk("ro_slverr", 32'h0000_0001, {31'h0000_0000, e});
      rdc(IDX_LANE4_FLAGS + 12'(i), 32'h0000_0000);
    end
    xfer(1'b0, 12'h04B7, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0000_0000, e});
    $display("test reset_ro done");
    // one sync bit at a time on every lane, then all lost
    for (int b = 0; b < 6; b++) begin
      sync <= (b < 5) ? {3{5'(1 << b)}} : 15'h0000;
      repeat (4) @(posedge clk);
      chk("flags", (b < 5) ? {8'h00, {3{8'(1 << b)}}} : 32'h0000_0000, {8'h00, flags});
      rdc(IDX_LANE6_FLAGS, (b < 5) ? 32'(1 << b) : 32'h0000_0000);
    end
    $display("test sync done");
    // counts just below and at the threshold, fast and slow bursts, saturation
    send(9'h001, 8'h02, 2'h0);
    chk("flags", 32'h0000_0000, {8'h00, flags});
    send(9'h001, 8'h01, 2'h0);
    send(9'h010, 8'h03, 2'h3);
    send(9'h100, 8'h03, 2'h1);
    chk("flags", 32'h0020_4080, {8'h00, flags});
    send(9'h040, 8'hFF, 2'h0);
    send(9'h040, 8'h02, 2'h0);
    rdc(IDX_LANE6_COUNT, 32'h0003_00FF);
    $display("test errors done");
    // sticky status, mask, write-one-to-clear
    rdc(IDX_IRQ_STATUS, 32'h0000_003F);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    xfer(1'b1, IDX_IRQ_MASK, 32'h0000_0001);
    @(posedge clk);
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    xfer(1'b1, IDX_IRQ_STATUS, 32'h0000_003F);
    @(posedge clk);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    rdc(IDX_IRQ_STATUS, 32'h0000_0000);
    $display("test irq done");
    // counter clear, then a zero threshold sets every error flag
    xfer(1'b1, IDX_CONTROL, 32'h0000_0001);
    rdc(IDX_LANE6_COUNT, 32'h0000_0000);
    {thr, skip, sync} <= {8'h00, 1'b1, 5'h05, 5'h1A, 5'h11};
    repeat (4) @(posedge clk);
    chk("flags", 32'h00E5_FAF1, {8'h00, flags});
    chk("skip", 32'h00E1_E0E1, {8'h00, flags & 24'hE1_E1E1});
    $display("test clear_thr done");
    // clock enable low: pulses meanwhile are dropped, counted again once running
    en <= 1'b0;
    send(9'h004, 8'h02, 2'h0);
    en <= 1'b1;
    rdc(IDX_LANE4_COUNT, 32'h0000_0000);
    send(9'h004, 8'h02, 2'h0);
    rdc(IDX_LANE4_COUNT, 32'h0002_0000);
    $display("test clk_en done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("flags", 32'h0000_0000, {8'h00, flags});
    rst <= 1'b0;
    @(posedge clk);
    // counts back to zero; flags rebuilt from zero threshold and lane5 sync levels
    rdc(IDX_LANE4_COUNT, 32'h0000_0000);
    rdc(IDX_LANE5_FLAGS, 32'h0000_00FA);
    $display("test reset_mid done");
    results();
  end
endmodule
`default_nettype wire
